// ==== rtl/mat_regs.vh ====
// Constants for the forwarding address table: sizes, aging limits, command codes.
// Included by mat_table.v, the assertions and the testbench.
`ifndef MAT_REGS_VH
`define MAT_REGS_VH

`define MAT_ENTRIES 16
`define MAT_IDX_W 4
`define MAT_PORTS 8
`define MAT_PORT_W 3
`define MAT_VLAN_W 12
`define MAT_MAC_W 48
`define MAT_AGE_W 10

// Aging time in seconds
`define MAT_AGE_MIN 10'h00a
`define MAT_AGE_MAX 10'h276
`define MAT_AGE_DEF 10'h12c

// Management command codes
`define MAT_OP_ADD 3'h0
`define MAT_OP_DEL 3'h1
`define MAT_OP_CONV 3'h2
`define MAT_OP_AGE 3'h3
`define MAT_OP_LIST 3'h4
`define MAT_OP_QUERY 3'h5

// Query filter bit positions
`define MAT_FLT_PORT 0
`define MAT_FLT_VLAN 1
`define MAT_FLT_MAC 2

`define MAT_FLOOD 8'hff

`endif

// ==== rtl/mat_table.v ====
// Forwarding address table: learning, lookup, aging, and management commands.
// Assumes all inputs come from logic on i_clock and i_sec_tick pulses once a second.
`timescale 1ns/100ps
`include "mat_regs.vh"

module mat_table (
    input wire i_clock, // Core clock, 40 MHz
    input wire i_rst, // Asynchronous reset, active high
    input wire i_sec_tick, // One-cycle pulse per second
    input wire i_learn_valid, // Source address learn strobe
    input wire [`MAT_MAC_W-1:0] i_learn_mac, // Source MAC
    input wire [`MAT_VLAN_W-1:0] i_learn_vlan, // Frame VLAN
    input wire [`MAT_PORT_W-1:0] i_learn_port, // Receiving port
    input wire i_lkup_valid, // Destination lookup strobe
    input wire [`MAT_MAC_W-1:0] i_lkup_mac, // Destination MAC
    input wire [`MAT_VLAN_W-1:0] i_lkup_vlan, // Frame VLAN
    input wire i_cmd_valid, // Management command strobe
    input wire [2:0] i_cmd_op, // Command code
    input wire [`MAT_MAC_W-1:0] i_cmd_mac, // Command MAC
    input wire [`MAT_VLAN_W-1:0] i_cmd_vlan, // Command VLAN
    input wire [`MAT_PORT_W-1:0] i_cmd_port, // Command port
    input wire [`MAT_AGE_W-1:0] i_cmd_age, // New aging time, seconds
    input wire [2:0] i_cmd_flt, // Query filter enables
    output reg o_lkup_done, // Lookup answer strobe
    output reg o_lkup_hit, // Lookup found an entry
    output reg [`MAT_PORTS-1:0] o_lkup_ports, // Egress ports
    output reg o_cmd_busy, // Listing in progress
    output reg o_cmd_done, // Command finished strobe
    output reg o_cmd_ok, // Command succeeded
    output reg [`MAT_AGE_W-1:0] o_age_time, // Current aging time
    output reg o_rpt_valid, // Reported entry strobe
    output reg [`MAT_MAC_W-1:0] o_rpt_mac, // Reported MAC
    output reg [`MAT_VLAN_W-1:0] o_rpt_vlan, // Reported VLAN
    output reg o_rpt_static, // Reported type, 1 = static
    output reg [`MAT_PORTS-1:0] o_rpt_ports // Reported member ports
);

localparam ST_IDLE = 1'b0;
localparam ST_LIST = 1'b1;
localparam KEY_W = `MAT_VLAN_W + `MAT_MAC_W;

reg e_valid [0:`MAT_ENTRIES-1];
reg e_static [0:`MAT_ENTRIES-1];
reg [`MAT_VLAN_W-1:0] e_vlan [0:`MAT_ENTRIES-1];
reg [`MAT_MAC_W-1:0] e_mac [0:`MAT_ENTRIES-1];
reg [`MAT_PORTS-1:0] e_ports [0:`MAT_ENTRIES-1];
reg [`MAT_AGE_W-1:0] e_age [0:`MAT_ENTRIES-1];

reg state;
reg first;
reg [KEY_W-1:0] last_key;
reg list_dyn;
reg [2:0] flt;
reg [`MAT_MAC_W-1:0] flt_mac;
reg [`MAT_VLAN_W-1:0] flt_vlan;
reg [`MAT_PORT_W-1:0] flt_port;
integer i, m;

////////////////////////////////////////////////////////////////////////////////
// Search helpers

// Returns {hit, index} of the entry holding this VLAN and MAC
function [`MAT_IDX_W:0] find_key;
    input [`MAT_VLAN_W-1:0] vlan;
    input [`MAT_MAC_W-1:0] mac;
    input [`MAT_ENTRIES-1:0] vld;
    input [`MAT_ENTRIES*KEY_W-1:0] keys;
    integer k;
    begin
        find_key = {1'b0, {`MAT_IDX_W{1'b0}}};
        for (k = 0; k < `MAT_ENTRIES; k = k + 1) begin
            if (vld[k] && keys[k*KEY_W +: KEY_W] == {vlan, mac}) begin
                find_key = {1'b1, k[`MAT_IDX_W-1:0]};
            end
        end
    end
endfunction

// Returns {hit, index} of the lowest free slot
function [`MAT_IDX_W:0] find_free;
    input [`MAT_ENTRIES-1:0] vld;
    integer k;
    begin
        find_free = {1'b0, {`MAT_IDX_W{1'b0}}};
        for (k = `MAT_ENTRIES - 1; k >= 0; k = k - 1) begin
            if (!vld[k]) begin
                find_free = {1'b1, k[`MAT_IDX_W-1:0]};
            end
        end
    end
endfunction

// Flat views of the table, so the searches re-evaluate on any entry change
wire [`MAT_ENTRIES-1:0] all_valid;
wire [`MAT_ENTRIES*KEY_W-1:0] all_keys;
genvar g;
for (g = 0; g < `MAT_ENTRIES; g = g + 1) begin : g_flat
    assign all_valid[g] = e_valid[g];
    assign all_keys[g*KEY_W +: KEY_W] = {e_vlan[g], e_mac[g]};
end

wire [`MAT_IDX_W:0] learn_hit = find_key(i_learn_vlan, i_learn_mac, all_valid, all_keys);
wire [`MAT_IDX_W:0] lkup_hit = find_key(i_lkup_vlan, i_lkup_mac, all_valid, all_keys);
wire [`MAT_IDX_W:0] cmd_hit = find_key(i_cmd_vlan, i_cmd_mac, all_valid, all_keys);
wire [`MAT_IDX_W:0] free_slot = find_free(all_valid);
wire cmd_take = i_cmd_valid && state == ST_IDLE;

////////////////////////////////////////////////////////////////////////////////
// Next entry in VLAN-then-MAC order, strictly above the last one reported

reg sel_found;
reg [`MAT_IDX_W-1:0] sel_idx;
reg [KEY_W-1:0] sel_key;

always @* begin
    sel_found = 1'b0;
    sel_idx = {`MAT_IDX_W{1'b0}};
    sel_key = {KEY_W{1'b0}};
    for (m = 0; m < `MAT_ENTRIES; m = m + 1) begin
        if (e_valid[m] && !(list_dyn && e_static[m])
                && (!flt[`MAT_FLT_PORT] || e_ports[m][flt_port])
                && (!flt[`MAT_FLT_VLAN] || e_vlan[m] == flt_vlan)
                && (!flt[`MAT_FLT_MAC] || e_mac[m] == flt_mac)
                && (first || {e_vlan[m], e_mac[m]} > last_key)
                && (!sel_found || {e_vlan[m], e_mac[m]} < sel_key)) begin
            sel_found = 1'b1;
            sel_idx = m[`MAT_IDX_W-1:0];
            sel_key = {e_vlan[m], e_mac[m]};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Table contents: aging, then learning, then management; later writes win

always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        for (i = 0; i < `MAT_ENTRIES; i = i + 1) begin
            e_valid[i] <= 1'b0;
            e_static[i] <= 1'b0;
            e_vlan[i] <= {`MAT_VLAN_W{1'b0}};
            e_mac[i] <= {`MAT_MAC_W{1'b0}};
            e_ports[i] <= {`MAT_PORTS{1'b0}};
            e_age[i] <= {`MAT_AGE_W{1'b0}};
        end
    end else begin
        if (i_sec_tick) begin
            for (i = 0; i < `MAT_ENTRIES; i = i + 1) begin
                if (e_valid[i] && !e_static[i]) begin
                    // Tick phase is free, so removal comes after age_time-1 to age_time seconds
                    if (e_age[i] + 10'h001 >= o_age_time) begin
                        e_valid[i] <= 1'b0;
                    end else begin
                        e_age[i] <= e_age[i] + 10'h001;
                    end
                end
            end
        end
        if (i_learn_valid) begin
            if (learn_hit[`MAT_IDX_W]) begin
                if (!e_static[learn_hit[`MAT_IDX_W-1:0]]) begin
                    e_valid[learn_hit[`MAT_IDX_W-1:0]] <= 1'b1;
                    e_ports[learn_hit[`MAT_IDX_W-1:0]] <= 8'h01 << i_learn_port;
                    e_age[learn_hit[`MAT_IDX_W-1:0]] <= {`MAT_AGE_W{1'b0}};
                end
            end else if (free_slot[`MAT_IDX_W] && !(cmd_take && i_cmd_op == `MAT_OP_ADD)) begin
                // Slot contention with an add: the learn is dropped, the next frame relearns
                e_valid[free_slot[`MAT_IDX_W-1:0]] <= 1'b1;
                e_static[free_slot[`MAT_IDX_W-1:0]] <= 1'b0;
                e_vlan[free_slot[`MAT_IDX_W-1:0]] <= i_learn_vlan;
                e_mac[free_slot[`MAT_IDX_W-1:0]] <= i_learn_mac;
                e_ports[free_slot[`MAT_IDX_W-1:0]] <= 8'h01 << i_learn_port;
                e_age[free_slot[`MAT_IDX_W-1:0]] <= {`MAT_AGE_W{1'b0}};
            end
        end
        if (cmd_take) begin
            case (i_cmd_op)
                `MAT_OP_ADD: begin
                    if (cmd_hit[`MAT_IDX_W]) begin
                        e_valid[cmd_hit[`MAT_IDX_W-1:0]] <= 1'b1;
                        e_static[cmd_hit[`MAT_IDX_W-1:0]] <= 1'b1;
                        e_ports[cmd_hit[`MAT_IDX_W-1:0]] <= 8'h01 << i_cmd_port;
                    end else if (free_slot[`MAT_IDX_W]) begin
                        e_valid[free_slot[`MAT_IDX_W-1:0]] <= 1'b1;
                        e_static[free_slot[`MAT_IDX_W-1:0]] <= 1'b1;
                        e_vlan[free_slot[`MAT_IDX_W-1:0]] <= i_cmd_vlan;
                        e_mac[free_slot[`MAT_IDX_W-1:0]] <= i_cmd_mac;
                        e_ports[free_slot[`MAT_IDX_W-1:0]] <= 8'h01 << i_cmd_port;
                        e_age[free_slot[`MAT_IDX_W-1:0]] <= {`MAT_AGE_W{1'b0}};
                    end
                end
                `MAT_OP_DEL: begin
                    if (cmd_hit[`MAT_IDX_W] && e_static[cmd_hit[`MAT_IDX_W-1:0]]) begin
                        e_valid[cmd_hit[`MAT_IDX_W-1:0]] <= 1'b0;
                        e_static[cmd_hit[`MAT_IDX_W-1:0]] <= 1'b0;
                    end
                end
                `MAT_OP_CONV: begin
                    if (cmd_hit[`MAT_IDX_W] && !e_static[cmd_hit[`MAT_IDX_W-1:0]]) begin
                        // Must also win over an age-out in this same cycle
                        e_valid[cmd_hit[`MAT_IDX_W-1:0]] <= 1'b1;
                        e_static[cmd_hit[`MAT_IDX_W-1:0]] <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Destination lookup, answered one cycle after the strobe

always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        o_lkup_done <= 1'b0;
        o_lkup_hit <= 1'b0;
        o_lkup_ports <= {`MAT_PORTS{1'b0}};
    end else begin
        o_lkup_done <= i_lkup_valid;
        o_lkup_hit <= i_lkup_valid && lkup_hit[`MAT_IDX_W];
        if (!i_lkup_valid) begin
            o_lkup_ports <= {`MAT_PORTS{1'b0}};
        end else if (lkup_hit[`MAT_IDX_W]) begin
            o_lkup_ports <= e_ports[lkup_hit[`MAT_IDX_W-1:0]];
        end else begin
            o_lkup_ports <= `MAT_FLOOD;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Management sequencer: single-cycle commands and the ordered listing

always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        state <= ST_IDLE;
        first <= 1'b1;
        last_key <= {KEY_W{1'b0}};
        list_dyn <= 1'b0;
        flt <= 3'h0;
        flt_mac <= {`MAT_MAC_W{1'b0}};
        flt_vlan <= {`MAT_VLAN_W{1'b0}};
        flt_port <= {`MAT_PORT_W{1'b0}};
        o_cmd_busy <= 1'b0;
        o_cmd_done <= 1'b0;
        o_cmd_ok <= 1'b0;
        o_age_time <= `MAT_AGE_DEF;
        o_rpt_valid <= 1'b0;
        o_rpt_mac <= {`MAT_MAC_W{1'b0}};
        o_rpt_vlan <= {`MAT_VLAN_W{1'b0}};
        o_rpt_static <= 1'b0;
        o_rpt_ports <= {`MAT_PORTS{1'b0}};
    end else begin
        o_cmd_done <= 1'b0;
        o_cmd_ok <= 1'b0;
        o_rpt_valid <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (cmd_take) begin
                    case (i_cmd_op)
                        `MAT_OP_ADD: begin
                            o_cmd_done <= 1'b1;
                            o_cmd_ok <= cmd_hit[`MAT_IDX_W] || free_slot[`MAT_IDX_W];
                        end
                        `MAT_OP_DEL: begin
                            o_cmd_done <= 1'b1;
                            o_cmd_ok <= cmd_hit[`MAT_IDX_W] && e_static[cmd_hit[`MAT_IDX_W-1:0]];
                        end
                        `MAT_OP_CONV: begin
                            o_cmd_done <= 1'b1;
                            o_cmd_ok <= cmd_hit[`MAT_IDX_W] && !e_static[cmd_hit[`MAT_IDX_W-1:0]];
                        end
                        `MAT_OP_AGE: begin
                            o_cmd_done <= 1'b1;
                            if (i_cmd_age >= `MAT_AGE_MIN && i_cmd_age <= `MAT_AGE_MAX) begin
                                o_age_time <= i_cmd_age;
                                o_cmd_ok <= 1'b1;
                            end
                        end
                        `MAT_OP_LIST, `MAT_OP_QUERY: begin
                            state <= ST_LIST;
                            o_cmd_busy <= 1'b1;
                            first <= 1'b1;
                            list_dyn <= i_cmd_op == `MAT_OP_QUERY;
                            // Full listing ignores the filter
                            flt <= (i_cmd_op == `MAT_OP_QUERY) ? i_cmd_flt : 3'h0;
                            flt_mac <= i_cmd_mac;
                            flt_vlan <= i_cmd_vlan;
                            flt_port <= i_cmd_port;
                        end
                        default: begin
                            o_cmd_done <= 1'b1;
                        end
                    endcase
                end
            end
            ST_LIST: begin
                // Table may change while listing; each step rescans the live contents
                if (sel_found) begin
                    first <= 1'b0;
                    last_key <= sel_key;
                    o_rpt_valid <= 1'b1;
                    o_rpt_mac <= e_mac[sel_idx];
                    o_rpt_vlan <= e_vlan[sel_idx];
                    o_rpt_static <= e_static[sel_idx];
                    o_rpt_ports <= e_ports[sel_idx];
                end else begin
                    state <= ST_IDLE;
                    o_cmd_busy <= 1'b0;
                    o_cmd_done <= 1'b1;
                    o_cmd_ok <= 1'b1;
                end
            end
            default: begin
                state <= ST_IDLE;
                o_cmd_busy <= 1'b0;
            end
        endcase
    end
end

endmodule // mat_table

// ==== test/mat_agent_model.sv ====
// Agent model: frame path strobes, management commands and the seconds tick.
// Assumes the bench calls send; every change lands on the falling clock edge.
`timescale 1ns/100ps
module mat_agent_model (
    input wire i_clock, // Core clock
    output reg o_sec_tick = 1'b0, // Seconds pulse
    output reg o_learn_valid = 1'b0, // Learn strobe
    output reg o_lkup_valid = 1'b0, // Lookup strobe
    output reg o_cmd_valid = 1'b0, // Command strobe
    output reg [47:0] o_mac = 48'h0, // Shared MAC bus
    output reg [11:0] o_vlan = 12'h0, // Shared VLAN bus
    output reg [2:0] o_port = 3'h0, // Shared port
    output reg [2:0] o_op = 3'h0, // Command code
    output reg [9:0] o_age = 10'h0, // Aging time
    output reg [2:0] o_flt = 3'h0 // Query filters
);
    // Released MAC, VLAN and age buses are inverted so a stale key never matches by luck
    task automatic send(input [3:0] sel, input [47:0] mac, input [11:0] vlan, input [2:0] port, input [2:0] op,
        input [9:0] age, input [2:0] flt);
        @(negedge i_clock);
        {o_sec_tick, o_cmd_valid, o_lkup_valid, o_learn_valid} = sel;
        {o_mac, o_vlan, o_port, o_op, o_age, o_flt} = {mac, vlan, port, op, age, flt};
        @(negedge i_clock);
        {o_sec_tick, o_cmd_valid, o_lkup_valid, o_learn_valid} = 4'h0;
        {o_mac, o_vlan, o_age} = {~mac, ~vlan, ~age};
    endtask
endmodule // mat_agent_model

// ==== test/mat_table_assertions.sv ====
// Port checks for the forwarding address table.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/100ps
`include "mat_regs.vh"
module mat_table_assertions (
    input wire i_clock, // Clock
    input wire i_rst, // Reset
    input wire i_lkup_valid, // Lookup strobe
    input wire i_cmd_valid, // Command strobe
    input wire [2:0] i_cmd_op, // Code
    input wire [`MAT_AGE_W-1:0] i_cmd_age, // New age
    input wire o_lkup_done, // Answer
    input wire o_lkup_hit, // Hit
    input wire [`MAT_PORTS-1:0] o_lkup_ports, // Ports
    input wire o_cmd_busy, // Busy
    input wire o_cmd_done, // Done
    input wire o_cmd_ok, // Ok
    input wire [`MAT_AGE_W-1:0] o_age_time, // Age
    input wire o_rpt_valid, // Report
    input wire [`MAT_MAC_W-1:0] o_rpt_mac, // MAC
    input wire [`MAT_VLAN_W-1:0] o_rpt_vlan // VLAN
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    wire take = i_cmd_valid && !o_cmd_busy;
    wire set_age = take && i_cmd_op == `MAT_OP_AGE;
    wire age_ok = i_cmd_age >= `MAT_AGE_MIN && i_cmd_age <= `MAT_AGE_MAX;
    wire lst = take && (i_cmd_op == `MAT_OP_LIST || i_cmd_op == `MAT_OP_QUERY);
    ////////////////////////////////////////
    property p_lkup_ans;
        i_lkup_valid |=> o_lkup_done && (o_lkup_hit ? o_lkup_ports != 8'h00 : o_lkup_ports == `MAT_FLOOD);
    endproperty
    a_lkup_ans: assert property (p_lkup_ans) else $error("lookup answer wrong");
    property p_lkup_quiet; !i_lkup_valid |=> !o_lkup_done && o_lkup_ports == 8'h00; endproperty
    a_lkup_quiet: assert property (p_lkup_quiet) else $error("lookup answer without request");
    property p_age_set; set_age && age_ok |=> o_cmd_done && o_cmd_ok && o_age_time == $past(i_cmd_age); endproperty
    a_age_set: assert property (p_age_set) else $error("aging time not taken");
    property p_age_bad; set_age && !age_ok |=> o_cmd_done && !o_cmd_ok && $stable(o_age_time); endproperty
    a_age_bad: assert property (p_age_bad) else $error("bad aging time accepted");
    property p_age_range; o_age_time >= `MAT_AGE_MIN && o_age_time <= `MAT_AGE_MAX; endproperty
    a_age_range: assert property (p_age_range) else $error("aging time out of range");
    property p_list_start; lst |=> o_cmd_busy && !o_cmd_done && !o_rpt_valid; endproperty
    a_list_start: assert property (p_list_start) else $error("listing did not start");
    property p_list_end; o_cmd_busy |-> ##[1:17] (o_cmd_done && !o_cmd_busy); endproperty
    a_list_end: assert property (p_list_end) else $error("listing did not end");
    property p_rpt_order;
        o_rpt_valid && $past(o_rpt_valid) |-> {o_rpt_vlan, o_rpt_mac} > {$past(o_rpt_vlan), $past(o_rpt_mac)};
    endproperty
    a_rpt_order: assert property (p_rpt_order) else $error("listing out of order");
    property p_rpt_in_list; o_rpt_valid |-> o_cmd_busy && !o_cmd_done; endproperty
    a_rpt_in_list: assert property (p_rpt_in_list) else $error("report outside listing");
    c_hit: cover property (o_lkup_done && o_lkup_hit);
    c_rpt: cover property (o_rpt_valid ##1 o_rpt_valid);
    c_age: cover property (set_age && age_ok);
endmodule // mat_table_assertions
bind mat_table mat_table_assertions mat_table_assertions_inst (.i_clock, .i_rst, .i_lkup_valid, .i_cmd_valid,
    .i_cmd_op, .i_cmd_age, .o_lkup_done, .o_lkup_hit, .o_lkup_ports, .o_cmd_busy, .o_cmd_done, .o_cmd_ok,
    .o_age_time, .o_rpt_valid, .o_rpt_mac, .o_rpt_vlan);

// ==== test/testbench.sv ====
// Bench for the forwarding address table: learning, lookup, aging, commands, listings.
// Assumes the agent model owns every table input except clock and reset and drives it on the falling edge.
`timescale 1ns/100ps
`include "mat_regs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    reg i_clock = 1'b0;
    reg i_rst = 1'b1;
    wire i_sec_tick, i_learn_valid, i_lkup_valid, i_cmd_valid, o_lkup_done, o_lkup_hit, o_cmd_busy, o_cmd_done;
    wire o_cmd_ok, o_rpt_valid, o_rpt_static;
    wire [47:0] a_mac, o_rpt_mac;
    wire [11:0] a_vlan, o_rpt_vlan;
    wire [2:0] a_port, i_cmd_op, i_cmd_flt;
    wire [9:0] i_cmd_age, o_age_time;
    wire [7:0] o_lkup_ports, o_rpt_ports;
    int error_cnt = 0;
    int comparisons = 0;
    logic [68:0] exp_q[$];
    logic [68:0] got_q[$];
    mat_table mat_table_inst (.i_clock, .i_rst, .i_sec_tick, .i_learn_valid, .i_learn_mac(a_mac),
        .i_learn_vlan(a_vlan), .i_learn_port(a_port), .i_lkup_valid, .i_lkup_mac(a_mac), .i_lkup_vlan(a_vlan),
        .i_cmd_valid, .i_cmd_op, .i_cmd_mac(a_mac), .i_cmd_vlan(a_vlan), .i_cmd_port(a_port), .i_cmd_age,
        .i_cmd_flt, .o_lkup_done, .o_lkup_hit, .o_lkup_ports, .o_cmd_busy, .o_cmd_done, .o_cmd_ok, .o_age_time,
        .o_rpt_valid, .o_rpt_mac, .o_rpt_vlan, .o_rpt_static, .o_rpt_ports);
    mat_agent_model mat_agent_model_inst (.i_clock, .o_sec_tick(i_sec_tick), .o_learn_valid(i_learn_valid),
        .o_lkup_valid(i_lkup_valid), .o_cmd_valid(i_cmd_valid), .o_mac(a_mac), .o_vlan(a_vlan), .o_port(a_port),
        .o_op(i_cmd_op), .o_age(i_cmd_age), .o_flt(i_cmd_flt));
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end
    ////////////////////////////////////////
    task automatic ln(input [47:0] mac, input [11:0] vlan, input [2:0] port);
        mat_agent_model_inst.send(4'h1, mac, vlan, port, 3'h0, 10'h0, 3'h0);
    endtask
    task automatic tk(input int n);
        repeat (n) mat_agent_model_inst.send(4'h8, 48'h0, 12'h0, 3'h0, 3'h0, 10'h0, 3'h0);
    endtask
    task automatic lk(input [47:0] mac, input [11:0] vlan, input hit, input [7:0] ports);
        mat_agent_model_inst.send(4'h2, mac, vlan, 3'h0, 3'h0, 10'h0, 3'h0);
        `CHK("lkup_done", 1'b1, o_lkup_done)
        `CHK("lkup_hit", hit, o_lkup_hit)
        `CHK("lkup_ports", ports, o_lkup_ports)
    endtask
    task automatic op(input [2:0] code, input [47:0] mac, input [11:0] vlan, input [2:0] port, input [9:0] age,
        input ok);
        mat_agent_model_inst.send(4'h4, mac, vlan, port, code, age, 3'h0);
        `CHK("cmd_done", 1'b1, o_cmd_done)
        `CHK("cmd_ok", ok, o_cmd_ok)
    endtask
    // Listing length is bounded by the table size, so 40 cycles is ample
    task automatic list(input [2:0] code, input [2:0] flt, input [2:0] port, input [11:0] vlan, input [47:0] mac);
        int n;
        n = 0;
        got_q.delete();
        mat_agent_model_inst.send(4'h4, mac, vlan, port, code, 10'h0, flt);
        `CHK("busy", 1'b1, o_cmd_busy)
        do begin
            @(negedge i_clock);
            if (o_rpt_valid === 1'b1) got_q.push_back({o_rpt_static, o_rpt_ports, o_rpt_vlan, o_rpt_mac});
            n++;
        end while (o_cmd_done !== 1'b1 && n < 40);
        `CHK("list_ok", 1'b1, o_cmd_ok)
        `CHK("busy_end", 1'b0, o_cmd_busy)
        `CHK("list_cnt", exp_q.size(), got_q.size())
        foreach (exp_q[i]) `CHK("entry", exp_q[i], got_q[i])
    endtask
    ////////////////////////////////////////
    task automatic t_learn;
        `CHK("age_rst", `MAT_AGE_DEF, o_age_time)
        ln(48'ha1, 12'h005, 3'h3);
        lk(48'ha1, 12'h005, 1'b1, 8'h08);
        lk(48'ha2, 12'h005, 1'b0, `MAT_FLOOD);
        lk(48'ha1, 12'h006, 1'b0, `MAT_FLOOD);
        ln(48'ha1, 12'h005, 3'h6);
        lk(48'ha1, 12'h005, 1'b1, 8'h40);
    endtask
    task automatic t_age;
        op(`MAT_OP_AGE, 48'h0, 12'h0, 3'h0, 10'h009, 1'b0);
        op(`MAT_OP_AGE, 48'h0, 12'h0, 3'h0, 10'h277, 1'b0);
        `CHK("age_keep", `MAT_AGE_DEF, o_age_time)
        op(`MAT_OP_AGE, 48'h0, 12'h0, 3'h0, `MAT_AGE_MAX, 1'b1);
        `CHK("age_max", `MAT_AGE_MAX, o_age_time)
        op(`MAT_OP_AGE, 48'h0, 12'h0, 3'h0, `MAT_AGE_MIN, 1'b1);
        op(`MAT_OP_ADD, 48'hb1, 12'h005, 3'h1, 10'h0, 1'b1);
        ln(48'hb2, 12'h003, 3'h0);
        ln(48'ha1, 12'h005, 3'h6);
        tk(9);
        lk(48'hb2, 12'h003, 1'b1, 8'h01);
        ln(48'ha1, 12'h005, 3'h6);
        tk(1);
        lk(48'hb2, 12'h003, 1'b0, `MAT_FLOOD);
        lk(48'ha1, 12'h005, 1'b1, 8'h40);
        lk(48'hb1, 12'h005, 1'b1, 8'h02);
    endtask
    task automatic t_static;
        op(`MAT_OP_ADD, 48'hc1, 12'h007, 3'h2, 10'h0, 1'b1);
        ln(48'hc1, 12'h007, 3'h5);
        lk(48'hc1, 12'h007, 1'b1, 8'h04);
        op(`MAT_OP_DEL, 48'hc1, 12'h007, 3'h0, 10'h0, 1'b1);
        lk(48'hc1, 12'h007, 1'b0, `MAT_FLOOD);
        op(`MAT_OP_DEL, 48'hc1, 12'h007, 3'h0, 10'h0, 1'b0);
        op(`MAT_OP_DEL, 48'ha1, 12'h005, 3'h0, 10'h0, 1'b0);
        op(`MAT_OP_CONV, 48'ha1, 12'h005, 3'h0, 10'h0, 1'b1);
        op(`MAT_OP_CONV, 48'ha1, 12'h005, 3'h0, 10'h0, 1'b0);
        op(3'h6, 48'h0, 12'h0, 3'h0, 10'h0, 1'b0);
        tk(12);
        lk(48'ha1, 12'h005, 1'b1, 8'h40);
    endtask
    task automatic t_list;
        ln(48'he1, 12'h002, 3'h7);
        ln(48'h05, 12'h005, 3'h0);
        exp_q = '{{1'b0, 8'h80, 12'h002, 48'he1}, {1'b0, 8'h01, 12'h005, 48'h05}, {1'b1, 8'h40, 12'h005, 48'ha1},
            {1'b1, 8'h02, 12'h005, 48'hb1}};
        list(`MAT_OP_LIST, 3'h7, 3'h0, 12'h005, 48'hb1);
        exp_q = '{{1'b0, 8'h01, 12'h005, 48'h05}};
        list(`MAT_OP_QUERY, 3'h2, 3'h0, 12'h005, 48'h0);
        list(`MAT_OP_QUERY, 3'h4, 3'h0, 12'h0, 48'h05);
        exp_q = '{{1'b0, 8'h80, 12'h002, 48'he1}};
        list(`MAT_OP_QUERY, 3'h1, 3'h7, 12'h0, 48'h0);
        // Learn and tick in one cycle: the refresh must beat the age-out
        tk(9);
        mat_agent_model_inst.send(4'h9, 48'he1, 12'h002, 3'h7, 3'h0, 10'h0, 3'h0);
        lk(48'he1, 12'h002, 1'b1, 8'h80);
        lk(48'h05, 12'h005, 1'b0, `MAT_FLOOD);
    endtask
    task automatic t_reset;
        @(negedge i_clock);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clock);
        i_rst = 1'b0;
        `CHK("age_rst2", `MAT_AGE_DEF, o_age_time)
        `CHK("busy_rst", 1'b0, o_cmd_busy)
        lk(48'ha1, 12'h005, 1'b0, `MAT_FLOOD);
    endtask
    task automatic results;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_clock);
        @(negedge i_clock);
        i_rst = 1'b0;
        t_learn();
        t_age();
        t_static();
        t_list();
        t_reset();
        results();
    end
    initial begin
        #100000;
        error_cnt++;
        results();
    end
endmodule // testbench
